// ==== hw/slrx_ctrl.sv ====
// Control registers of the serial link receiver, reached over the config port
//
// Contract
// - Rising edge of calibration bit B calibrates lanes 2 to 5 terminations.
// - Rising edge of calibration bit A calibrates lanes 0, 1, 6 and 7.
// - Device computes local config checksum by chosen method, stores per link.
// - Method 0 sums the individual link configuration fields.
// - Method 1 sums packed config bytes 0x450 to 0x45a modulo 256.
// - Control bit 3 selects single link (0) or dual link (1) mode.
// - Control bit 2 pages addresses 0x401 to 0x47e to link 0 or 1.
// - Control bits 1:0 enable receiver logic per link, bit 0 is link 0.
// - Enable code 00 disables both, 01 only link 0, 10 only link 1.
// - Enable code 11 enables both links together.
`include "slrx_ctrl_defs.svh"

module slrx_ctrl #(
    parameter int CFG_BYTES = `SLRX_CFG_BYTES
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    // Configuration serial port pins
    input  wire logic                     cfg_cs_n,
    input  wire logic                     cfg_sclk,
    input  wire logic                     cfg_sdi,
    output logic                          cfg_sdo_o,
    output logic                          cfg_sdo_oe,
    // Packed link configuration bytes of each link, byte 0 at 0x450
    input  wire logic [8*CFG_BYTES-1:0]   link_cfg_0,
    input  wire logic [8*CFG_BYTES-1:0]   link_cfg_1,
    // Paged register window toward the per-link maps
    output logic                          paged_wr,
    output logic                          paged_rd,
    output logic                          paged_link,
    output logic [14:0]                   paged_addr,
    output logic [7:0]                    paged_wdata,
    input  wire logic [7:0]               paged_rdata,
    // Controls toward the PHY and receiver logic
    output logic                          term_cal_trigger_a,
    output logic                          term_cal_trigger_b,
    output logic [7:0]                    lane_term_tune_a,
    output logic [7:0]                    lane_term_tune_b,
    output logic                          dual_link_mode,
    output logic                          link0_enable,
    output logic                          link1_enable,
    output logic                          checksum_mode,
    output logic [7:0]                    lane_checksum_compare_0,
    output logic [7:0]                    lane_checksum_compare_1
);

    // The checksum functions index a fixed eleven byte layout
    if (CFG_BYTES != `SLRX_CFG_BYTES) begin : g_bad_cfg_bytes
        $error("slrx_ctrl: CFG_BYTES must be 11");
    end

    slrx_ctrl_pkg::slrx_state_t st_reg;
    slrx_ctrl_pkg::slrx_state_t st_next;

    // Method 0: sum of the individual fields of the packed table
    function automatic logic [7:0] slrx_sum_fields(
        input logic [8*CFG_BYTES-1:0] cfg
    );
        logic [7:0] s;
        s = cfg[7:0];                                     // Device id
        s = s + {4'h0, cfg[11:8]};                        // Bank id
        s = s + {3'h0, cfg[20:16]};                       // Lane id
        s = s + {7'h00, cfg[31]};                         // Scrambling
        s = s + {3'h0, cfg[28:24]};                       // Lanes minus 1
        s = s + cfg[39:32];                               // Octets minus 1
        s = s + {3'h0, cfg[44:40]};                       // Frames minus 1
        s = s + cfg[55:48];                               // Converters - 1
        s = s + {6'h00, cfg[63:62]};                      // Control bits
        s = s + {3'h0, cfg[60:56]};                       // Resolution - 1
        s = s + {5'h00, cfg[71:69]};                      // Subclass
        s = s + {3'h0, cfg[68:64]};                       // Total bits - 1
        s = s + {5'h00, cfg[79:77]};                      // Version
        s = s + {3'h0, cfg[76:72]};                       // Samples - 1
        s = s + {7'h00, cfg[87]};                         // High density
        s = s + {3'h0, cfg[84:80]};                       // Control words
        return s;
    endfunction : slrx_sum_fields

    // Method 1: byte sum of the packed registers, wrapping at 256
    function automatic logic [7:0] slrx_sum_bytes(
        input logic [8*CFG_BYTES-1:0] cfg
    );
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < CFG_BYTES; i++) begin
            s = s + cfg[8*i +: 8];
        end
        return s;
    endfunction : slrx_sum_bytes

    function automatic logic [7:0] slrx_checksum(
        input logic                   mode,
        input logic [8*CFG_BYTES-1:0] cfg
    );
        return mode ? slrx_sum_bytes(cfg)
                    : slrx_sum_fields(cfg);
    endfunction : slrx_checksum

    // Local register read; unmapped and reserved bits give zero
    function automatic logic [7:0] slrx_read_local(
        input logic [14:0]               addr,
        input slrx_ctrl_pkg::slrx_state_t s
    );
        unique case (addr)
            `SLRX_OFS_TERM_CAL_A: return s.term_cal_ctrl_a;
            `SLRX_OFS_TERM_CAL_B: return s.term_cal_ctrl_b;
            `SLRX_OFS_TUNE_A:     return s.lane_term_tune_a;
            `SLRX_OFS_TUNE_B:     return s.lane_term_tune_b;
            `SLRX_OFS_LINK_CTRL:  return s.receiver_link_ctrl;
            default:              return 8'h00;
        endcase
    endfunction : slrx_read_local

    function automatic logic slrx_is_paged(input logic [14:0] addr);
        return (addr >= `SLRX_OFS_PAGE_LO) && (addr <= `SLRX_OFS_PAGE_HI);
    endfunction : slrx_is_paged

    // Next state: pin filter, serial framing, register writes, checksums
    always_comb begin
        logic        sclk_rise;
        logic        sclk_fall;
        logic [7:0]  wdata;
        logic [14:0] addr;
        st_next = st_reg;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        wdata = {st_reg.shift_in[6:0], st_reg.sdi_f};
        addr = st_reg.instr[14:0];

        // Three stage capture; a level counts once stages two and three agree
        st_next.cs_n_sync = {st_reg.cs_n_sync[1:0], cfg_cs_n};
        st_next.sclk_sync = {st_reg.sclk_sync[1:0], cfg_sclk};
        st_next.sdi_sync  = {st_reg.sdi_sync[1:0], cfg_sdi};
        if (st_reg.cs_n_sync[1] == st_reg.cs_n_sync[2]) begin
            st_next.cs_n_f = st_reg.cs_n_sync[2];
        end
        if (st_reg.sclk_sync[1] == st_reg.sclk_sync[2]) begin
            st_next.sclk_f = st_reg.sclk_sync[2];
        end
        if (st_reg.sdi_sync[1] == st_reg.sdi_sync[2]) begin
            st_next.sdi_f = st_reg.sdi_sync[2];
        end

        // Pulses last one cycle
        st_next.term_cal_start_a = 1'b0;
        st_next.term_cal_start_b = 1'b0;
        st_next.paged_wr = 1'b0;
        st_next.paged_rd = 1'b0;
        st_next.rd_load = 1'b0;

        if (st_reg.cs_n_f) begin
            // Deselected: frame restarts and the data pin is released
            st_next.bit_cnt = 5'h00;
            st_next.frame_done = 1'b0;
            st_next.sdo_oe = 1'b0;
        end else begin
            sclk_rise = st_next.sclk_f & ~st_reg.sclk_f;
            sclk_fall = ~st_next.sclk_f & st_reg.sclk_f;
        end

        // Sample on the rising clock edge after the filtered data settled
        if (sclk_rise && !st_reg.frame_done) begin
            st_next.shift_in = wdata;
            if (st_reg.bit_cnt < `SLRX_INSTR_BITS) begin
                st_next.instr = {st_reg.instr[14:0], st_reg.sdi_f};
            end
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == `SLRX_INSTR_BITS - 5'h01) begin
                st_next.rd_load = 1'b1;
            end
            if (st_reg.bit_cnt == `SLRX_LAST_BIT) begin
                // Single byte frames; extra clocks are ignored until deselect
                st_next.frame_done = 1'b1;
                if (!st_reg.instr[15]) begin
                    unique case (addr)
                        `SLRX_OFS_TERM_CAL_A: begin
                            st_next.term_cal_ctrl_a =
                                wdata & `SLRX_MASK_TERM_CAL;
                            st_next.term_cal_start_a =
                                wdata[`SLRX_BIT_CAL_TRIGGER] &
                                ~st_reg.term_cal_ctrl_a[0];
                        end
                        `SLRX_OFS_TERM_CAL_B: begin
                            st_next.term_cal_ctrl_b =
                                wdata & `SLRX_MASK_TERM_CAL;
                            st_next.term_cal_start_b =
                                wdata[`SLRX_BIT_CAL_TRIGGER] &
                                ~st_reg.term_cal_ctrl_b[0];
                        end
                        `SLRX_OFS_TUNE_A: st_next.lane_term_tune_a = wdata;
                        `SLRX_OFS_TUNE_B: st_next.lane_term_tune_b = wdata;
                        `SLRX_OFS_LINK_CTRL: begin
                            st_next.receiver_link_ctrl =
                                wdata & `SLRX_MASK_LINK_CTRL;
                        end
                        default: begin
                            if (slrx_is_paged(addr)) begin
                                st_next.paged_wr = 1'b1;
                                st_next.paged_addr = addr;
                                st_next.paged_wdata = wdata;
                            end
                        end
                    endcase
                end
            end
        end

        // Read data loads one cycle after the instruction completes
        if (st_reg.rd_load && st_reg.instr[15]) begin
            st_next.sdo_oe = 1'b1;
            if (slrx_is_paged(addr)) begin
                st_next.paged_rd = 1'b1;
                st_next.paged_addr = addr;
            end else begin
                st_next.shift_out = slrx_read_local(addr, st_reg);
            end
        end
        // Paged data is taken while the strobe stands
        if (st_reg.paged_rd) begin
            st_next.shift_out = paged_rdata;
        end
        // Output shifts on the falling edge so the host samples it rising
        if (sclk_fall && st_reg.sdo_oe &&
            st_reg.bit_cnt > `SLRX_INSTR_BITS) begin
            st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
        end
        if (st_reg.frame_done && sclk_fall) begin
            st_next.sdo_oe = 1'b0;
        end

        // Checksums recomputed every cycle from the live configuration
        st_next.checksum_0 = slrx_checksum(
            st_reg.receiver_link_ctrl[`SLRX_BIT_CSUM_MODE],
            link_cfg_0);
        st_next.checksum_1 = slrx_checksum(
            st_reg.receiver_link_ctrl[`SLRX_BIT_CSUM_MODE],
            link_cfg_1);

        // Synchronous reset; chip select idles high so no false frame
        if (sys_rst) begin
            st_next = '0;
            st_next.cs_n_sync = 3'h7;
            st_next.cs_n_f = 1'b1;
            st_next.term_cal_ctrl_a = `SLRX_RST_TERM_CAL;
            st_next.term_cal_ctrl_b = `SLRX_RST_TERM_CAL;
            st_next.lane_term_tune_a = `SLRX_RST_TUNE_A;
            st_next.lane_term_tune_b = `SLRX_RST_TUNE_B;
            st_next.receiver_link_ctrl = `SLRX_RST_LINK_CTRL;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    // Port drive, all from flip-flops
    assign cfg_sdo_o = st_reg.shift_out[7];
    assign cfg_sdo_oe = st_reg.sdo_oe;
    assign paged_wr = st_reg.paged_wr;
    assign paged_rd = st_reg.paged_rd;
    assign paged_addr = st_reg.paged_addr;
    assign paged_wdata = st_reg.paged_wdata;
    assign paged_link =
        st_reg.receiver_link_ctrl[`SLRX_BIT_LINK_PAGE];
    assign term_cal_trigger_a = st_reg.term_cal_start_a;
    assign term_cal_trigger_b = st_reg.term_cal_start_b;
    assign lane_term_tune_a = st_reg.lane_term_tune_a;
    assign lane_term_tune_b = st_reg.lane_term_tune_b;
    assign dual_link_mode =
        st_reg.receiver_link_ctrl[`SLRX_BIT_LINK_MODE];
    // Each enable bit acts alone, so all four codes fall out directly
    assign link0_enable =
        st_reg.receiver_link_ctrl[`SLRX_BIT_LINK0_EN];
    assign link1_enable =
        st_reg.receiver_link_ctrl[`SLRX_BIT_LINK1_EN];
    assign checksum_mode =
        st_reg.receiver_link_ctrl[`SLRX_BIT_CSUM_MODE];
    assign lane_checksum_compare_0 = st_reg.checksum_0;
    assign lane_checksum_compare_1 = st_reg.checksum_1;

endmodule : slrx_ctrl

// ==== hw/slrx_ctrl_defs.svh ====
// Offsets, field positions, reset values and framing counts for slrx_ctrl
`ifndef SLRX_CTRL_DEFS_SVH
`define SLRX_CTRL_DEFS_SVH

// Register offsets on the configuration port
`define SLRX_OFS_TERM_CAL_A      15'h02a7
`define SLRX_OFS_TERM_CAL_B      15'h02ae
`define SLRX_OFS_TUNE_A          15'h02b1
`define SLRX_OFS_TUNE_B          15'h02b2
`define SLRX_OFS_LINK_CTRL       15'h0300
`define SLRX_OFS_PAGE_LO         15'h0401
`define SLRX_OFS_PAGE_HI         15'h047e

// Field positions in receiver_link_ctrl and the calibration registers
`define SLRX_BIT_CSUM_MODE       6
`define SLRX_BIT_LINK_MODE       3
`define SLRX_BIT_LINK_PAGE       2
`define SLRX_BIT_LINK0_EN        0
`define SLRX_BIT_LINK1_EN        1
`define SLRX_BIT_CAL_TRIGGER     0

// Writable bit masks, everything else is reserved
`define SLRX_MASK_LINK_CTRL      8'h4f
`define SLRX_MASK_TERM_CAL       8'h01

// Reset values
`define SLRX_RST_TUNE_A          8'hc3
`define SLRX_RST_TUNE_B          8'h93
`define SLRX_RST_LINK_CTRL       8'h00
`define SLRX_RST_TERM_CAL        8'h00

// Serial frame: 16 instruction bits then 8 data bits
`define SLRX_INSTR_BITS          5'h10
`define SLRX_LAST_BIT            5'h17
`define SLRX_CFG_BYTES           11

`endif

// ==== hw/slrx_ctrl_pkg.sv ====
// Types shared by the serial link receiver control registers
package slrx_ctrl_pkg;

    // Whole state of the register block, registered in one place
    typedef struct packed {
        logic [2:0]  cs_n_sync;
        logic [2:0]  sclk_sync;
        logic [2:0]  sdi_sync;
        logic        cs_n_f;
        logic        sclk_f;
        logic        sdi_f;
        logic [4:0]  bit_cnt;
        logic        frame_done;
        logic [15:0] instr;
        logic [7:0]  shift_in;
        logic [7:0]  shift_out;
        logic        sdo_oe;
        logic        rd_load;
        logic [7:0]  term_cal_ctrl_a;
        logic [7:0]  term_cal_ctrl_b;
        logic [7:0]  lane_term_tune_a;
        logic [7:0]  lane_term_tune_b;
        logic [7:0]  receiver_link_ctrl;
        logic        term_cal_start_a;
        logic        term_cal_start_b;
        logic        paged_wr;
        logic        paged_rd;
        logic [14:0] paged_addr;
        logic [7:0]  paged_wdata;
        logic [7:0]  checksum_0;
        logic [7:0]  checksum_1;
    } slrx_state_t;

endpackage : slrx_ctrl_pkg

// ==== tb/slrx_ctrl_monitor.sv ====
// Concurrent checks on the ports of the receiver control registers
module slrx_ctrl_monitor #(
    parameter int CFG_BYTES = 11
) (
    // Clock and reset
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    // Serial port
    input wire logic                   cfg_cs_n,
    input wire logic                   cfg_sdo_oe,
    // Checksum inputs and results of both links
    input wire logic [8*CFG_BYTES-1:0] link_cfg_0,
    input wire logic [8*CFG_BYTES-1:0] link_cfg_1,
    input wire logic [7:0]             lane_checksum_compare_0,
    input wire logic [7:0]             lane_checksum_compare_1,
    // Paged window
    input wire logic                   paged_wr,
    input wire logic                   paged_rd,
    input wire logic [14:0]            paged_addr,
    // Controls
    input wire logic                   term_cal_trigger_a,
    input wire logic                   term_cal_trigger_b,
    input wire logic [7:0]             lane_term_tune_a,
    input wire logic                   dual_link_mode,
    input wire logic                   link0_enable,
    input wire logic                   link1_enable,
    input wire logic                   checksum_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Own reference sums, kept apart from the design's logic
    function automatic logic [7:0] bsum(input logic [8*CFG_BYTES-1:0] c);
        bsum = 8'h00;
        for (int i = 0; i < CFG_BYTES; i++) bsum += c[8*i+:8];
    endfunction : bsum

    function automatic logic [7:0] fsum(input logic [8*CFG_BYTES-1:0] c);
        fsum = c[7:0] + c[11:8] + c[20:16] + c[31] + c[28:24] + c[39:32]
            + c[44:40] + c[55:48] + c[63:62] + c[60:56] + c[71:69]
            + c[68:64] + c[79:77] + c[76:72] + c[87] + c[84:80];
    endfunction : fsum

    tune_reset_a: assert property ($fell(sys_rst) |->
        lane_term_tune_a == 8'hc3) else $error("tune reset value wrong");
    cal_a_pulse_a: assert property (term_cal_trigger_a |=>
        !term_cal_trigger_a) else $error("trigger a too long");
    cal_b_pulse_a: assert property (term_cal_trigger_b |=>
        !term_cal_trigger_b) else $error("trigger b too long");
    cal_apart_a: assert property (term_cal_trigger_a |->
        !term_cal_trigger_b) else $error("both triggers at once");
    page_range_a: assert property ((paged_wr || paged_rd) |->
        paged_addr inside {[15'h0401:15'h047e]}) else $error("page addr");
    page_pulse_a: assert property (paged_wr |=>
        !paged_wr && !paged_rd) else $error("paged strobe too long");
    ctrl_quiet_a: assert property (cfg_cs_n [*8] |->
        $stable({dual_link_mode, link0_enable, link1_enable,
        checksum_mode})) else $error("control changed while idle");
    sdo_idle_a: assert property (cfg_cs_n [*6] |->
        !cfg_sdo_oe) else $error("sdo driven while idle");
    csum_track_a: assert property (1'b1 |=>
        lane_checksum_compare_0 == ($past(checksum_mode) ?
        bsum($past(link_cfg_0)) : fsum($past(link_cfg_0))))
        else $error("checksum wrong");
    csum_link1_a: assert property (1'b1 |=>
        lane_checksum_compare_1 == ($past(checksum_mode) ?
        bsum($past(link_cfg_1)) : fsum($past(link_cfg_1))))
        else $error("checksum of link 1 wrong");

    // Main scenarios reached
    c_cal_b: cover property (term_cal_trigger_b);
    c_page_rd: cover property (paged_rd);
    c_dual: cover property (dual_link_mode && link0_enable && link1_enable);
endmodule : slrx_ctrl_monitor

bind slrx_ctrl slrx_ctrl_monitor #(.CFG_BYTES(CFG_BYTES)) u_mon (
    .sys_clk, .sys_rst, .cfg_cs_n, .cfg_sdo_oe, .link_cfg_0, .link_cfg_1,
    .lane_checksum_compare_0, .lane_checksum_compare_1,
    .paged_wr, .paged_rd, .paged_addr,
    .term_cal_trigger_a, .term_cal_trigger_b, .lane_term_tune_a,
    .dual_link_mode, .link0_enable, .link1_enable, .checksum_mode);

// ==== tb/slrx_ctrl_tb.sv ====
// Self-checking bench for the receiver control registers
module slrx_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cfg_cs_n = 1'b1, cfg_sclk = 1'b0, cfg_sdi = 1'b0;
    logic        cfg_sdo_o, cfg_sdo_oe, paged_wr, paged_rd, paged_link;
    logic [87:0] link_cfg_0 = 88'h0, link_cfg_1 = 88'h0;
    logic [14:0] paged_addr;
    logic [7:0]  paged_wdata, paged_rdata = 8'h00, rd_byte;
    logic        term_cal_trigger_a, term_cal_trigger_b, dual_link_mode;
    logic        link0_enable, link1_enable, checksum_mode;
    logic [7:0]  lane_term_tune_a, lane_term_tune_b;
    logic [7:0]  lane_checksum_compare_0, lane_checksum_compare_1;
    logic [31:0] exp_q[$];
    logic        rd_pend = 1'b0;
    int          fail_count = 0, n_compared = 0, cyc = 0;

    slrx_ctrl u_dut (.sys_clk, .sys_rst, .cfg_cs_n, .cfg_sclk, .cfg_sdi,
        .cfg_sdo_o, .cfg_sdo_oe, .link_cfg_0, .link_cfg_1, .paged_wr,
        .paged_rd, .paged_link, .paged_addr, .paged_wdata, .paged_rdata,
        .term_cal_trigger_a, .term_cal_trigger_b, .lane_term_tune_a,
        .lane_term_tune_b, .dual_link_mode, .link0_enable, .link1_enable,
        .checksum_mode, .lane_checksum_compare_0, .lane_checksum_compare_1);

    always #2 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Ceiling well above the roughly 21k cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            end_sim();
        end
    end

    // Every pulse or readback is matched with the oldest note
    always @(posedge sys_clk) begin
        logic [31:0] seen;
        seen = 32'h0;
        if (term_cal_trigger_a === 1'b1) seen = 32'h0100_0000;
        if (term_cal_trigger_b === 1'b1) seen = 32'h0200_0000;
        if (paged_wr === 1'b1) seen = {8'h03, 1'b0, paged_addr, paged_wdata};
        if (paged_rd === 1'b1) begin
            seen = {8'h04, 1'b0, paged_addr, 7'h0, paged_link};
        end
        if (rd_pend) seen = {8'h05, 16'h0, rd_byte};
        rd_pend = 1'b0;
        if (seen != 32'h0) begin
            if (exp_q.size() == 0) check(seen, 32'h0);
            else check(seen, exp_q.pop_front());
        end
    end

    // One frame, MSB first; nb below 24 cuts it short
    task automatic frame(input logic rw, input logic [14:0] a,
                         input logic [7:0] d, input int nb);
        logic [23:0] w;
        w = {rw, a, d};
        cfg_cs_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        for (int i = 23; i >= 24 - nb; i--) begin
            cfg_sdi = w[i];
            repeat (8) @(negedge sys_clk);
            if (i < 8) rd_byte[i] = cfg_sdo_o;
            cfg_sclk = 1'b1;
            repeat (8) @(negedge sys_clk);
            cfg_sclk = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        cfg_cs_n = 1'b1;
        if (rw && nb == 24) rd_pend = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask : frame

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        frame(1'b0, a, d, 24);
    endtask : wr

    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        exp_q.push_back({8'h05, 16'h0, e});
        frame(1'b1, a, 8'h00, 24);
    endtask : rd

    initial begin
        logic [7:0]  d;
        logic [14:0] a;
        void'($urandom(72095));
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        check(lane_term_tune_a, 8'hc3);
        check(lane_term_tune_b, 8'h93);
        rd(15'h02ae, 8'h00);
        rd(15'h02b1, 8'hc3);
        rd(15'h02b2, 8'h93);
        rd(15'h0300, 8'h00);
        $display("test reset done");
        wr(15'h02b1, 8'hb7);
        wr(15'h02b2, 8'h87);
        // A frame cut short must leave the register alone
        frame(1'b0, 15'h02b1, 8'h11, 12);
        check(lane_term_tune_a, 8'hb7);
        check(lane_term_tune_b, 8'h87);
        rd(15'h02b1, 8'hb7);
        $display("test tuning done");
        // Only a 0 to 1 change of the bit fires calibration
        exp_q.push_back(32'h0200_0000);
        wr(15'h02ae, 8'hff);
        rd(15'h02ae, 8'h01);
        wr(15'h02ae, 8'h01);
        wr(15'h02ae, 8'h00);
        exp_q.push_back(32'h0200_0000);
        wr(15'h02ae, 8'h01);
        exp_q.push_back(32'h0100_0000);
        wr(15'h02a7, 8'hfd);
        rd(15'h02a7, 8'h01);
        $display("test calibration done");
        // All four enable codes in single and dual link mode, with random link config
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom());
            d[1:0] = i[1:0];
            d[3] = i[2];
            d[6] = ~i[0];
            link_cfg_0 = 88'({$urandom(), $urandom(), $urandom()});
            link_cfg_1 = 88'({$urandom(), $urandom(), $urandom()});
            wr(15'h0300, d);
            check(dual_link_mode, d[3]);
            check(paged_link, d[2]);
            check(link0_enable, d[0]);
            check({link1_enable, link0_enable}, d[1:0]);
            check(checksum_mode, d[6]);
            rd(15'h0300, d & 8'h4f);
        end
        $display("test link control done");
        for (int p = 0; p < 2; p++) begin
            wr(15'h0300, {5'h00, p[0], 2'b01});
            for (int j = 0; j < 5; j++) begin
                a = (j == 4) ? 15'h0401 + 15'($urandom_range(125)) :
                    (j == 0) ? 15'h0401 : (j == 1) ? 15'h047e :
                    (j == 2) ? 15'h0400 : 15'h047f;
                d = 8'($urandom());
                paged_rdata = 8'($urandom());
                if (a inside {[15'h0401:15'h047e]}) begin
                    exp_q.push_back({8'h03, 1'b0, a, d});
                    wr(a, d);
                    exp_q.push_back({8'h04, 1'b0, a, 7'h0, p[0]});
                    rd(a, paged_rdata);
                end else begin
                    wr(a, d);
                    rd(a, 8'h00);
                end
            end
        end
        $display("test paging done");
        check(32'(exp_q.size()), 32'h0);
        end_sim();
    end
endmodule : slrx_ctrl_tb
